// File: design/lptm_pkg.sv
package lptm_pkg;
    // apb register offsets (byte addresses)
    localparam logic [7:0] LPTM_CTRL_OFF = 8'h00;
    localparam logic [7:0] LPTM_RATED_OFF = 8'h04;
    localparam logic [7:0] LPTM_THR_OFF = 8'h08;
    localparam logic [7:0] LPTM_DLY_OFF = 8'h0c;
    localparam logic [7:0] LPTM_SETTLE_OFF = 8'h10;
    localparam logic [7:0] LPTM_POWER_OFF = 8'h14;
    localparam logic [7:0] LPTM_STAT_OFF = 8'h18;
    localparam logic [7:0] LPTM_IRQ_OFF = 8'h1c;
    localparam logic [7:0] LPTM_MASK_OFF = 8'h20;
    // ctrl field positions
    localparam int LPTM_CTRL_MODE_BIT = 0;
    localparam int LPTM_CTRL_ENFN_BIT = 1;
    localparam int LPTM_CTRL_OUTFN_BIT = 2;
    // interrupt bit positions
    localparam int LPTM_IRQ_RISE_BIT = 0;
    localparam int LPTM_IRQ_FALL_BIT = 1;
    localparam int LPTM_IRQ_CFG_BIT = 2;
    // reset values
    localparam logic [31:0] LPTM_CTRL_RST = 32'h0000_0000;
    localparam logic [15:0] LPTM_RATED_RST = 16'h0064;
    localparam logic [7:0] LPTM_THR_RST = 8'h00;
    localparam logic [15:0] LPTM_DLY_RST = 16'h0000;
    // timing: one second at the 10 mhz pclk
    localparam int LPTM_CLK_HZ = 10_000_000;
    localparam int LPTM_SECOND_S = 1;
    localparam int LPTM_TICK_CYCLES = LPTM_CLK_HZ * LPTM_SECOND_S;

    // monitor configuration carried as one bundle
    typedef struct packed {
        logic high_mode; // monitor high power when set
        logic en_fn_assigned; // an input carries the enable function
        logic out_fn_assigned; // an output carries the threshold function
        logic [7:0] lower_pct; // lower threshold percent
        logic [7:0] upper_pct; // upper threshold percent
        logic [15:0] lower_dly; // lower delay seconds
        logic [15:0] upper_dly; // upper delay seconds
        logic [15:0] settle_dly; // settling delay seconds
        logic [15:0] rated; // rated power
    } lptm_cfg_t;
endpackage

// File: design/lptm_monitor.sv
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
module lptm_monitor #(
    parameter int TICK_CYCLES = lptm_pkg::LPTM_TICK_CYCLES // cycles per second
)(
    input wire logic pclk, // apb clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic threshold_enable_input_fn, // enable digital input level
    output logic threshold_output_fn, // status digital output
    output logic irq // level interrupt
);
    typedef enum {ST_IDLE, ST_SETTLE, ST_RUN} lptm_state_t;

    lptm_pkg::lptm_cfg_t cfg_q, cfg_d; // software configuration
    logic [15:0] power_q, power_d; // measured power sample
    logic [2:0] irq_q, irq_d; // sticky events
    logic [2:0] mask_q, mask_d; // interrupt enables
    logic [31:0] prdata_q, prdata_d; // read data register
    logic pready_q, pready_d; // ready register
    logic pslverr_q, pslverr_d; // error register
    logic out_q, out_d; // status output
    logic irq_out_q, irq_out_d; // interrupt output
    lptm_state_t st_q, st_d; // monitor state
    logic [23:0] tick_q, tick_d; // one second prescaler
    logic [15:0] low_cnt_q, low_cnt_d; // seconds below lower
    logic [15:0] high_cnt_q, high_cnt_d; // seconds above upper
    logic [15:0] settle_q, settle_d; // settling seconds left
    logic en_q, en_d; // previous enable level

    // scale a percent threshold to power units
    function automatic logic [15:0] pct_of(input logic [7:0] pct, input logic [15:0] rated);
        logic [23:0] prod;
        prod = 24'(rated) * 24'(pct);
        return 16'(prod / 24'd100);
    endfunction

    // advance a qualification counter, restart when condition lapses
    function automatic logic [15:0] qual(input logic cond, input logic tick,
                                         input logic [15:0] cnt);
        logic [15:0] r;
        r = cnt;
        if (!cond)
            r = 16'h0000;
        else if (tick && cnt != 16'hffff)
            r = cnt + 16'h0001;
        return r;
    endfunction

    logic apb_wr, apb_rd, tick, cfg_ok, enabled, en_rise; // decoded terms
    logic [15:0] lo_lvl, hi_lvl; // thresholds in power units
    logic below, above, lo_done, hi_done; // comparisons and qualifications

    // combinational decode of the monitor conditions
    always_comb
    begin
        apb_wr = psel && penable && pwrite && !pready_q;
        apb_rd = psel && penable && !pwrite && !pready_q;
        tick = (tick_q == 24'(TICK_CYCLES - 1));
        lo_lvl = pct_of(cfg_q.lower_pct, cfg_q.rated);
        hi_lvl = pct_of(cfg_q.upper_pct, cfg_q.rated);
        cfg_ok = (cfg_q.lower_pct != 8'h00) && (cfg_q.upper_pct != 8'h00)
            && (cfg_q.lower_pct < cfg_q.upper_pct);
        enabled = cfg_ok && cfg_q.out_fn_assigned
            && (!cfg_q.en_fn_assigned || threshold_enable_input_fn);
        en_rise = cfg_q.en_fn_assigned && threshold_enable_input_fn && !en_q;
        below = power_q < lo_lvl;
        above = power_q > hi_lvl;
        lo_done = (low_cnt_q >= cfg_q.lower_dly) && below;
        hi_done = (high_cnt_q >= cfg_q.upper_dly) && above;
    end

    // next state of monitor, timers and output
    always_comb
    begin
        st_d = st_q;
        out_d = out_q;
        tick_d = tick ? 24'h000000 : tick_q + 24'h000001;
        low_cnt_d = qual(below, tick, low_cnt_q);
        high_cnt_d = qual(above, tick, high_cnt_q);
        settle_d = settle_q;
        en_d = threshold_enable_input_fn;
        if (!enabled)
        begin
            // function off: output released
            st_d = ST_IDLE;
            out_d = 1'b0;
        end
        else if (en_rise)
        begin
            // input just became active: settle first
            st_d = ST_SETTLE;
            settle_d = cfg_q.settle_dly;
            out_d = 1'b0;
            tick_d = 24'h000000;
        end
        else
        begin
            case (st_q)
                ST_IDLE:
                begin
                    // entered without an input edge
                    st_d = ST_RUN;
                    low_cnt_d = 16'h0000;
                    high_cnt_d = 16'h0000;
                end
                ST_SETTLE:
                begin
                    // force off while counting down
                    out_d = 1'b0;
                    if (settle_q == 16'h0000)
                    begin
                        st_d = ST_RUN;
                        low_cnt_d = 16'h0000;
                        high_cnt_d = 16'h0000;
                    end
                    else if (tick)
                        settle_d = settle_q - 16'h0001;
                end
                default:
                begin
                    if (!cfg_q.high_mode)
                    begin
                        if (lo_done)
                            out_d = 1'b1;
                        else if (hi_done)
                            out_d = 1'b0;
                    end
                    else
                    begin
                        if (above)
                            out_d = 1'b1;
                        else if (below)
                            out_d = 1'b0;
                    end
                end
            endcase
        end
    end

    // register bus, interrupt status and read mux
    always_comb
    begin
        cfg_d = cfg_q;
        power_d = power_q;
        mask_d = mask_q;
        irq_d = irq_q;
        prdata_d = prdata_q;
        pready_d = psel && penable && !pready_q;
        pslverr_d = 1'b0;
        if (apb_wr)
        begin
            if (paddr == lptm_pkg::LPTM_CTRL_OFF)
            begin
                cfg_d.high_mode = pwdata[lptm_pkg::LPTM_CTRL_MODE_BIT];
                cfg_d.en_fn_assigned = pwdata[lptm_pkg::LPTM_CTRL_ENFN_BIT];
                cfg_d.out_fn_assigned = pwdata[lptm_pkg::LPTM_CTRL_OUTFN_BIT];
            end
            else if (paddr == lptm_pkg::LPTM_RATED_OFF)
                cfg_d.rated = pwdata[15:0];
            else if (paddr == lptm_pkg::LPTM_THR_OFF)
            begin
                cfg_d.lower_pct = pwdata[7:0];
                cfg_d.upper_pct = pwdata[15:8];
            end
            else if (paddr == lptm_pkg::LPTM_DLY_OFF)
            begin
                cfg_d.lower_dly = pwdata[15:0];
                cfg_d.upper_dly = pwdata[31:16];
            end
            else if (paddr == lptm_pkg::LPTM_SETTLE_OFF)
                cfg_d.settle_dly = pwdata[15:0];
            else if (paddr == lptm_pkg::LPTM_POWER_OFF)
                power_d = pwdata[15:0];
            else if (paddr == lptm_pkg::LPTM_IRQ_OFF)
                irq_d = irq_q & ~pwdata[2:0];
            else if (paddr == lptm_pkg::LPTM_MASK_OFF)
                mask_d = pwdata[2:0];
            else if (paddr != lptm_pkg::LPTM_STAT_OFF)
                pslverr_d = 1'b1;
        end
        else if (apb_rd)
        begin
            if (paddr == lptm_pkg::LPTM_CTRL_OFF)
                prdata_d = {29'h0, cfg_q.out_fn_assigned, cfg_q.en_fn_assigned,
                    cfg_q.high_mode};
            else if (paddr == lptm_pkg::LPTM_RATED_OFF)
                prdata_d = {16'h0, cfg_q.rated};
            else if (paddr == lptm_pkg::LPTM_THR_OFF)
                prdata_d = {16'h0, cfg_q.upper_pct, cfg_q.lower_pct};
            else if (paddr == lptm_pkg::LPTM_DLY_OFF)
                prdata_d = {cfg_q.upper_dly, cfg_q.lower_dly};
            else if (paddr == lptm_pkg::LPTM_SETTLE_OFF)
                prdata_d = {16'h0, cfg_q.settle_dly};
            else if (paddr == lptm_pkg::LPTM_POWER_OFF)
                prdata_d = {16'h0, power_q};
            else if (paddr == lptm_pkg::LPTM_STAT_OFF)
                prdata_d = {27'h0, st_q == ST_SETTLE, enabled, cfg_ok, enabled, out_q};
            else if (paddr == lptm_pkg::LPTM_IRQ_OFF)
                prdata_d = {29'h0, irq_q};
            else if (paddr == lptm_pkg::LPTM_MASK_OFF)
                prdata_d = {29'h0, mask_q};
            else
            begin
                prdata_d = 32'h0000_0000;
                pslverr_d = 1'b1;
            end
        end
        // events set after the clear so a same-cycle event wins
        if (out_d && !out_q)
            irq_d[lptm_pkg::LPTM_IRQ_RISE_BIT] = 1'b1;
        if (!out_d && out_q)
            irq_d[lptm_pkg::LPTM_IRQ_FALL_BIT] = 1'b1;
        if (!cfg_ok && cfg_q.out_fn_assigned)
            irq_d[lptm_pkg::LPTM_IRQ_CFG_BIT] = 1'b1;
        irq_out_d = |(irq_d & mask_d);
    end

    // state registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_q <= '{high_mode: 1'b0, en_fn_assigned: 1'b0, out_fn_assigned: 1'b0,
                lower_pct: lptm_pkg::LPTM_THR_RST, upper_pct: lptm_pkg::LPTM_THR_RST,
                lower_dly: lptm_pkg::LPTM_DLY_RST, upper_dly: lptm_pkg::LPTM_DLY_RST,
                settle_dly: lptm_pkg::LPTM_DLY_RST, rated: lptm_pkg::LPTM_RATED_RST};
            power_q <= 16'h0000;
            irq_q <= 3'h0;
            mask_q <= 3'h0;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            out_q <= 1'b0;
            irq_out_q <= 1'b0;
            st_q <= ST_IDLE;
            tick_q <= 24'h000000;
            low_cnt_q <= 16'h0000;
            high_cnt_q <= 16'h0000;
            settle_q <= 16'h0000;
            en_q <= 1'b0;
        end
        else
        begin
            cfg_q <= cfg_d;
            power_q <= power_d;
            irq_q <= irq_d;
            mask_q <= mask_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            out_q <= out_d;
            irq_out_q <= irq_out_d;
            st_q <= st_d;
            tick_q <= tick_d;
            low_cnt_q <= low_cnt_d;
            high_cnt_q <= high_cnt_d;
            settle_q <= settle_d;
            en_q <= en_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign threshold_output_fn = out_q;
    assign irq = irq_out_q;
endmodule

// File: sim/lptm_monitor_sva.sv
`timescale 1ns/10ps
module lptm_monitor_sva #(
    parameter int TICK_CYCLES = 10 // cycles per second
)(
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic psel, // select
    input wire logic penable, // enable
    input wire logic pwrite, // direction
    input wire logic [7:0] paddr, // address
    input wire logic [31:0] pwdata, // write data
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic threshold_enable_input_fn, // enable input
    input wire logic threshold_output_fn, // status output
    input wire logic irq // interrupt
);
    logic [2:0] ctrl_q; // shadow of ctrl bits
    logic thr_ok_q; // thresholds nonzero and ordered
    logic take; // write accepted at this edge
    assign take = psel && penable && !pready && pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // shadow ctrl as seen on the bus
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            ctrl_q <= 3'h0;
        else if (take && paddr == lptm_pkg::LPTM_CTRL_OFF)
            ctrl_q <= pwdata[2:0];
    // shadow threshold sanity as seen on the bus
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            thr_ok_q <= 1'b0;
        else if (take && paddr == lptm_pkg::LPTM_THR_OFF)
            thr_ok_q <= (pwdata[7:0] != 8'h00) && (pwdata[7:0] < pwdata[15:8]);
    chk_ready_wait:
    assert property (psel && penable && !pready |=> pready) else $error("no ready");
    chk_ready_once:
    assert property (pready |=> !pready) else $error("ready too long");
    chk_ready_phase:
    assert property (pready |-> psel && penable) else $error("ready outside access");
    chk_err_pair:
    assert property (pslverr |-> pready) else $error("error without ready");
    chk_err_data:
    assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("error data");
    chk_outfn_off:
    assert property (!ctrl_q[2] [*4] |-> !threshold_output_fn) else $error("unassigned out");
    chk_thr_bad:
    assert property (!thr_ok_q [*4] |-> !threshold_output_fn) else $error("bad thresholds");
    chk_enable_gate:
    assert property ((ctrl_q[1] && !threshold_enable_input_fn) [*4] |-> !threshold_output_fn)
    else $error("monitor not gated");
    chk_settle_hold:
    assert property ($rose(threshold_enable_input_fn) && ctrl_q[1] && !threshold_output_fn
        |=> !threshold_output_fn) else $error("output during settle");
endmodule
bind lptm_monitor lptm_monitor_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .threshold_enable_input_fn(threshold_enable_input_fn),
    .threshold_output_fn(threshold_output_fn));

// File: sim/lptm_io_model.sv
`timescale 1ns/10ps
module lptm_io_model (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic en_req, // requested input level
    output logic threshold_enable_input_fn // enable input pin
);
    // the pin moves only just after a clock edge
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            threshold_enable_input_fn <= 1'b0;
        else
            threshold_enable_input_fn <= en_req;
endmodule

// File: sim/test_load_power_threshold_monitor.sv
`timescale 1ns/10ps
module test_load_power_threshold_monitor;
    typedef struct packed {
        logic [2:0] ctrl; // mode and assignment bits
        logic [15:0] thr; // upper and lower percent
        logic [15:0] rated; // rated power
        logic [15:0] pow; // measured power
        logic out; // expected status
    } lptm_row_t;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic en_req = 1'b0, pready, pslverr, en_in, out, irq, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int fails = 0, samples_checked = 0;
    lptm_row_t rows [11] = '{'{3'h4, 16'h3214, 16'h0064, 16'h000a, 1'b1},
        '{3'h4, 16'h3214, 16'h0064, 16'h003c, 1'b0}, '{3'h4, 16'h3214, 16'h0064, 16'h001e, 1'b0},
        '{3'h5, 16'h3214, 16'h0064, 16'h003c, 1'b1}, '{3'h5, 16'h3214, 16'h0064, 16'h001e, 1'b1},
        '{3'h5, 16'h3214, 16'h0064, 16'h000a, 1'b0}, '{3'h5, 16'h3214, 16'h00c8, 16'h003c, 1'b0},
        '{3'h5, 16'h3214, 16'h00c8, 16'h0078, 1'b1}, '{3'h1, 16'h3214, 16'h0064, 16'h0078, 1'b0},
        '{3'h5, 16'h3232, 16'h0064, 16'h003c, 1'b0}, '{3'h5, 16'h3200, 16'h0064, 16'h003c, 1'b0}};
    always #50 pclk = ~pclk;
    lptm_monitor #(.TICK_CYCLES(10)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .threshold_enable_input_fn(en_in),
        .threshold_output_fn(out), .irq(irq));
    lptm_io_model io (.pclk(pclk), .presetn(presetn), .en_req(en_req),
        .threshold_enable_input_fn(en_in));
    task automatic report_and_stop();
        if (fails == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one apb transfer, held until ready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            fails++;
            report_and_stop();
        end
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    // bounded wait for the status output
    task automatic wait_out(input logic v, input int lim);
        int n;
        n = 0;
        while (out !== v && n < lim)
        begin
            @(posedge pclk);
            n++;
        end
        chk("status wait", {31'h0, v}, {31'h0, out});
        // only a wait that ran out ends the run early
        if (out !== v)
            report_and_stop();
    endtask
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i])
        begin
            wr(lptm_pkg::LPTM_RATED_OFF, {16'h0, rows[i].rated});
            wr(lptm_pkg::LPTM_THR_OFF, {16'h0, rows[i].thr});
            wr(lptm_pkg::LPTM_CTRL_OFF, {29'h0, rows[i].ctrl});
            wr(lptm_pkg::LPTM_POWER_OFF, {16'h0, rows[i].pow});
            repeat (6) @(posedge pclk);
            chk("status row", {31'h0, rows[i].out}, {31'h0, out});
        end
        // last rows left bad thresholds with the output assigned
        apb(1'b0, lptm_pkg::LPTM_IRQ_OFF, 32'h0);
        chk("cfg flag", 32'h1, {31'h0, rd[2]});
        // qualification delays in seconds, interrupt raise, mask and clear
        // low mode goes in first so the band never opens in high mode
        wr(lptm_pkg::LPTM_CTRL_OFF, 32'h4);
        wr(lptm_pkg::LPTM_DLY_OFF, 32'h0001_0002);
        wr(lptm_pkg::LPTM_THR_OFF, 32'h3214);
        wr(lptm_pkg::LPTM_IRQ_OFF, 32'h7);
        wr(lptm_pkg::LPTM_POWER_OFF, 32'h000a);
        repeat (6) @(posedge pclk);
        chk("early status", 32'h0, {31'h0, out});
        wait_out(1'b1, 40);
        chk("masked irq", 32'h0, {31'h0, irq});
        apb(1'b0, lptm_pkg::LPTM_IRQ_OFF, 32'h0);
        chk("rise flag", 32'h1, {31'h0, rd[0]});
        wr(lptm_pkg::LPTM_MASK_OFF, 32'h1);
        repeat (3) @(posedge pclk);
        chk("irq set", 32'h1, {31'h0, irq});
        wr(lptm_pkg::LPTM_IRQ_OFF, 32'h1);
        repeat (3) @(posedge pclk);
        chk("irq clear", 32'h0, {31'h0, irq});
        wr(lptm_pkg::LPTM_POWER_OFF, 32'h003c);
        wait_out(1'b0, 40);
        // enable input gating and settling time
        wr(lptm_pkg::LPTM_DLY_OFF, 32'h0);
        wr(lptm_pkg::LPTM_SETTLE_OFF, 32'h3);
        wr(lptm_pkg::LPTM_CTRL_OFF, 32'h6);
        wr(lptm_pkg::LPTM_POWER_OFF, 32'h000a);
        repeat (6) @(posedge pclk);
        chk("gated status", 32'h0, {31'h0, out});
        en_req <= 1'b1;
        repeat (15) @(posedge pclk);
        chk("settle status", 32'h0, {31'h0, out});
        wait_out(1'b1, 60);
        // status word: output, enabled, config good, enabled, not settling
        apb(1'b0, lptm_pkg::LPTM_STAT_OFF, 32'h0);
        chk("stat word", 32'h0000_000f, rd);
        // unmapped place is refused
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, 8'h40, 32'h0);
        chk("unmapped wr err", 32'h1, {31'h0, er});
        // second reset in mid-run restores defaults
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("reset status", 32'h0, {31'h0, out});
        apb(1'b0, lptm_pkg::LPTM_RATED_OFF, 32'h0);
        chk("rated reset", 32'h64, rd);
        apb(1'b0, lptm_pkg::LPTM_THR_OFF, 32'h0);
        chk("thr reset", 32'h0, rd);
        report_and_stop();
    end
endmodule
